//--- verilog/nvr_pkg.sv
/*
  Shared constants and BCD helpers for the timekeeping RAM.
  Assumes a single 10 MHz clock and BCD-coded clock registers.
*/
package nvr_pkg;
  localparam int ADDR_W = 15;
  localparam int RAM_DEPTH = 32768;
  localparam logic [ADDR_W-1:0] CLK_BASE = 15'h7FF8;
  // Clock register index within the top eight bytes
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_SEC = 3'h1;
  localparam logic [2:0] IDX_MIN = 3'h2;
  localparam logic [2:0] IDX_HOUR = 3'h3;
  localparam logic [2:0] IDX_DAY = 3'h4;
  localparam logic [2:0] IDX_DATE = 3'h5;
  localparam logic [2:0] IDX_MON = 3'h6;
  localparam logic [2:0] IDX_YEAR = 3'h7;
  localparam int CTRL_W_BIT = 7;
  localparam int CTRL_R_BIT = 6;
  localparam int SEC_OSC_BIT = 7;
  localparam int DAY_BF_BIT = 7;
  localparam int DAY_FT_BIT = 6;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] CENT_MAX = 8'h39;
  localparam logic [7:0] ZERO_BCD = 8'h00;
  localparam logic [7:0] ONE_BCD = 8'h01;
  localparam logic [63:0] TIME_RST = 64'h0001010100000020;
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_FREQ_HZ * TICK_PERIOD_S;
  // Interrupt side port
  localparam logic IRQ_ADDR_STAT = 1'b0;
  localparam logic IRQ_ADDR_MASK = 1'b1;
  localparam int IRQ_TICK_BIT = 0;
  localparam int IRQ_PFAIL_BIT = 1;
  localparam int IRQ_BLOW_BIT = 2;
  localparam logic [7:0] IRQ_RST = 8'h00;

  function automatic logic [7:0] nvrBcdInc(input logic [7:0] v, input logic [7:0] mx,
                                           input logic [7:0] mn);
    if (v >= mx) return mn;
    else if (v[3:0] >= 4'h9) return {v[7:4] + 4'h1, 4'h0};
    else return {v[7:4], v[3:0] + 4'h1};
  endfunction : nvrBcdInc

  function automatic logic nvrDiv4(input logic [7:0] v);
    return (!v[4] && (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8)) ||
           (v[4] && (v[3:0] == 4'h2 || v[3:0] == 4'h6));
  endfunction : nvrDiv4

  function automatic logic [7:0] nvrMonthLast(input logic [7:0] mon, input logic leap);
    unique case (mon)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : nvrMonthLast
endpackage : nvr_pkg

//--- verilog/nvr_ram.sv
/*
  Byte-wide storage array with registered read data.
  Assumes write and address are sampled on the rising clock edge.
*/
`timescale 1ns/1ps
module nvr_ram
  import nvr_pkg::*;
(
  // Clock
  input wire logic clock,
  // Access
  input wire logic [ADDR_W-1:0] addr,
  input wire logic writeEn,
  input wire logic [7:0] writeData,
  output logic [7:0] readData
);
  logic [7:0] mem [RAM_DEPTH];

  always_ff @(posedge clock) begin
    if (writeEn) begin
      mem[addr] <= writeData;
    end
    readData <= mem[addr];
  end
endmodule : nvr_ram

//--- verilog/nvr_calendar.sv
/*
  Internal BCD time and calendar counters, the hidden half of the
  double buffer. Assumes tick is a one-cycle pulse once per second.
*/
`timescale 1ns/1ps
module nvr_calendar
  import nvr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0][7:0] loadTime,
  // Count, byte i sits at clock register index i
  output logic [7:0][7:0] calTime
);
  logic [7:0][7:0] time_reg;
  logic [7:0][7:0] time_next;
  logic leap;
  logic [7:0] yrNext;

  assign calTime = time_reg;

  always_comb begin
    time_next = time_reg;
    leap = nvrDiv4(time_reg[IDX_YEAR]) &&
           (time_reg[IDX_YEAR] != ZERO_BCD || nvrDiv4(time_reg[IDX_CTRL]));
    yrNext = nvrBcdInc(time_reg[IDX_YEAR], YEAR_MAX, ZERO_BCD);
    if (load) begin
      time_next = loadTime;
    end else if (tick) begin
      time_next[IDX_SEC] = nvrBcdInc(time_reg[IDX_SEC], SEC_MAX, ZERO_BCD);
      if (time_reg[IDX_SEC] == SEC_MAX) begin
        time_next[IDX_MIN] = nvrBcdInc(time_reg[IDX_MIN], SEC_MAX, ZERO_BCD);
        if (time_reg[IDX_MIN] == SEC_MAX) begin
          time_next[IDX_HOUR] = nvrBcdInc(time_reg[IDX_HOUR], HOUR_MAX, ZERO_BCD);
          if (time_reg[IDX_HOUR] == HOUR_MAX) begin
            time_next[IDX_DAY] = nvrBcdInc(time_reg[IDX_DAY], DAY_MAX, ONE_BCD);
            // Month length and leap day, century years by century
            time_next[IDX_DATE] = nvrBcdInc(time_reg[IDX_DATE],
                nvrMonthLast(time_reg[IDX_MON], leap), ONE_BCD);
            if (time_reg[IDX_DATE] >= nvrMonthLast(time_reg[IDX_MON], leap)) begin
              time_next[IDX_MON] = nvrBcdInc(time_reg[IDX_MON], MON_MAX, ONE_BCD);
              if (time_reg[IDX_MON] == MON_MAX) begin
                time_next[IDX_YEAR] = yrNext;
                if (time_reg[IDX_YEAR] == YEAR_MAX) begin
                  time_next[IDX_CTRL] = nvrBcdInc(time_reg[IDX_CTRL], CENT_MAX, ZERO_BCD);
                end
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      time_reg <= TIME_RST;
    end else begin
      time_reg <= time_next;
    end
  end
endmodule : nvr_calendar

//--- verilog/nvr_top.sv
/*
  Timekeeping RAM: 32k x 8 storage with BCD clock in the top eight
  bytes, byte bus with low-active enables, power-fail gating, open-drain
  reset and a small interrupt side port.
  Assumes all pins are synchronous to clock; supplyOk and backupOk come
  from external comparators; the byte bus and reset pins are resolved
  from their enables outside.
*/
// Implementation choices: the register addresses and the plain strobed port.
// Behaviour
// - 32k bytes, clock in top eight
// - Clock bytes accessed like plain RAM
// - BCD century to seconds, 24-hour hours
// - Month lengths and leap day through 2100
// - Visible bytes double-buffered from counters
// - Counting never stalls for host access
// - Supply fault blocks every byte-bus access
// - Select high ignores other enables
// - Output enable low drives read data
// - Write enable low stores data
// - Reset output only pulls low
// - Readable backup source good flag
// - Enable decode: deselect, write, read
// - Write bit freezes, 00h loads clock
// - Read bit freezes view, count continues
// - Seconds top bit stops oscillator
`timescale 1ns/1ps
module nvr_top
  import nvr_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Byte bus
  input wire logic [ADDR_W-1:0] addrLine,
  input wire logic [7:0] dataLineIn,
  output logic [7:0] dataLineOut,
  output logic dataLineEnN,
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic writeEnN,
  // Power monitor
  input wire logic supplyOk,
  input wire logic backupOk,
  output logic rstLineOut,
  output logic rstLineEnN,
  // Interrupt side port
  input wire logic irqAddr,
  input wire logic [7:0] irqWdata,
  input wire logic irqWr,
  input wire logic irqRd,
  output logic [7:0] irqRdata,
  output logic irq
);
  logic accessOk;
  logic wrHit;
  logic rdHit;
  logic isClk;
  logic [2:0] idx;
  logic ramWe;
  logic [7:0] ramRdata;
  logic tick;
  logic loadCal;
  logic [7:0][7:0] loadVal;
  logic [7:0][7:0] calTime;
  logic [7:0] clkByte;
  logic [7:0] events;

  logic [7:0][7:0] vis_reg, vis_next;
  logic wBit_reg, wBit_next;
  logic rBit_reg, rBit_next;
  logic oscStop_reg, oscStop_next;
  logic ftBit_reg, ftBit_next;
  logic [23:0] tickCnt_reg, tickCnt_next;
  logic rdPend_reg, rdPend_next;
  logic rdClk_reg, rdClk_next;
  logic [7:0] clkByte_reg, clkByte_next;
  logic [7:0] dataOut_reg, dataOut_next;
  logic enN_reg, enN_next;
  logic rstEnN_reg, rstEnN_next;
  logic supplyD_reg, supplyD_next;
  logic backupD_reg, backupD_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] irqRd_reg, irqRd_next;
  logic irq_reg, irq_next;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Bus decode, gated by the power monitor
  always_comb begin
    accessOk = supplyOk && !chipSelN;
    wrHit = accessOk && !writeEnN;
    rdHit = accessOk && writeEnN && !outEnN;
    isClk = addrLine[ADDR_W-1:3] == CLK_BASE[ADDR_W-1:3];
    idx = addrLine[2:0];
    ramWe = wrHit;
  end

  nvr_ram u_ram (
    .clock(clock),
    .addr(addrLine),
    .writeEn(ramWe),
    .writeData(dataLineIn),
    .readData(ramRdata)
  );

  // Time base and load transfer
  always_comb begin
    tickCnt_next = tickCnt_reg + 24'h000001;
    if (tickCnt_reg >= 24'(TICK_CYCLES_P - 1)) begin
      tickCnt_next = 24'h000000;
    end
    if (oscStop_reg) begin
      tickCnt_next = tickCnt_reg;
    end
    tick = !oscStop_reg && tickCnt_reg >= 24'(TICK_CYCLES_P - 1);
    // Clearing the write bit moves the loaded view into the counters
    loadCal = wrHit && isClk && idx == IDX_CTRL && wBit_reg &&
              !dataLineIn[CTRL_W_BIT];
    loadVal = vis_reg;
    loadVal[IDX_CTRL] = {2'b00, dataLineIn[5:0]};
  end

  nvr_calendar u_cal (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick),
    .load(loadCal),
    .loadTime(loadVal),
    .calTime(calTime)
  );

  // Visible registers and control bits
  always_comb begin
    vis_next = vis_reg;
    wBit_next = wBit_reg;
    rBit_next = rBit_reg;
    oscStop_next = oscStop_reg;
    ftBit_next = ftBit_reg;
    if (!wBit_reg && !rBit_reg) begin
      vis_next = calTime;
    end
    if (wrHit && isClk) begin
      if (idx == IDX_CTRL) begin
        wBit_next = dataLineIn[CTRL_W_BIT];
        rBit_next = dataLineIn[CTRL_R_BIT];
      end else if (wBit_reg) begin
        vis_next[idx] = dataLineIn;
      end
      if (idx == IDX_SEC) begin
        oscStop_next = dataLineIn[SEC_OSC_BIT];
        vis_next[IDX_SEC][SEC_OSC_BIT] = 1'b0;
      end
      if (idx == IDX_DAY) begin
        ftBit_next = dataLineIn[DAY_FT_BIT];
        vis_next[IDX_DAY][7:3] = 5'h00;
      end
    end
  end

  // Read path: view byte, then pin register
  always_comb begin
    clkByte = vis_reg[idx];
    unique case (idx)
      IDX_CTRL: clkByte = {wBit_reg, rBit_reg, vis_reg[IDX_CTRL][5:0]};
      IDX_SEC: clkByte = {oscStop_reg, vis_reg[IDX_SEC][6:0]};
      IDX_DAY: clkByte = {backupOk, ftBit_reg, 3'b000, vis_reg[IDX_DAY][2:0]};
      default: clkByte = vis_reg[idx];
    endcase
    rdPend_next = rdHit;
    rdClk_next = isClk;
    clkByte_next = clkByte;
    dataOut_next = rdClk_reg ? clkByte_reg : ramRdata;
    enN_next = !(rdPend_reg && rdHit);
    rstEnN_next = supplyOk;
  end

  // Interrupt status, mask and side-port reads
  always_comb begin
    supplyD_next = supplyOk;
    backupD_next = backupOk;
    events = 8'h00;
    events[IRQ_TICK_BIT] = tick;
    events[IRQ_PFAIL_BIT] = supplyD_reg && !supplyOk;
    events[IRQ_BLOW_BIT] = backupD_reg && !backupOk;
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (irqWr && irqAddr == IRQ_ADDR_STAT) begin
      stat_next = stat_reg & ~irqWdata;
    end
    if (irqWr && irqAddr == IRQ_ADDR_MASK) begin
      mask_next = irqWdata;
    end
    stat_next = stat_next | events;
    irqRd_next = 8'h00;
    if (irqRd) begin
      irqRd_next = (irqAddr == IRQ_ADDR_STAT) ? stat_reg : mask_reg;
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vis_reg <= TIME_RST;
      wBit_reg <= 1'b0;
      rBit_reg <= 1'b0;
      oscStop_reg <= 1'b0;
      ftBit_reg <= 1'b0;
      tickCnt_reg <= 24'h000000;
      rdPend_reg <= 1'b0;
      rdClk_reg <= 1'b0;
      clkByte_reg <= 8'h00;
      dataOut_reg <= 8'h00;
      enN_reg <= 1'b1;
      rstEnN_reg <= 1'b0;
      supplyD_reg <= 1'b0;
      backupD_reg <= 1'b0;
      stat_reg <= IRQ_RST;
      mask_reg <= IRQ_RST;
      irqRd_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      vis_reg <= vis_next;
      wBit_reg <= wBit_next;
      rBit_reg <= rBit_next;
      oscStop_reg <= oscStop_next;
      ftBit_reg <= ftBit_next;
      tickCnt_reg <= tickCnt_next;
      rdPend_reg <= rdPend_next;
      rdClk_reg <= rdClk_next;
      clkByte_reg <= clkByte_next;
      dataOut_reg <= dataOut_next;
      enN_reg <= enN_next;
      rstEnN_reg <= rstEnN_next;
      supplyD_reg <= supplyD_next;
      backupD_reg <= backupD_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irqRd_reg <= irqRd_next;
      irq_reg <= irq_next;
    end
  end

  assign dataLineOut = dataOut_reg;
  assign dataLineEnN = enN_reg;
  // Open drain: the pin value is always low, only the enable moves
  assign rstLineOut = 1'b0;
  assign rstLineEnN = rstEnN_reg;
  assign irqRdata = irqRd_reg;
  assign irq = irq_reg;

  sequence readHeld;
    rdHit ##1 rdHit;
  endsequence

  readFloat_a: assert property (!rdHit |=> dataLineEnN)
    else $error("data lines driven without a read");
  pfBlock_a: assert property (!supplyOk |-> !ramWe ##1 (dataLineEnN && !rstLineEnN))
    else $error("access or release during supply fault");
  selIgnore_a: assert property (chipSelN |-> !ramWe)
    else $error("write taken while deselected");
  writeCap_a: assert property (supplyOk && !chipSelN && !writeEnN |-> ramWe)
    else $error("write cycle not stored");
  readDrive_a: assert property (readHeld |=> !dataLineEnN)
    else $error("held read did not drive data");
  viewFrozen_a: assert property (rBit_reg && !wBit_reg |=> $stable(vis_reg))
    else $error("view changed while read bit set");
  loadXfer_a: assert property (loadCal |=> calTime == $past(loadVal) && !wBit_reg)
    else $error("loaded view not transferred");
  oscHold_a: assert property (oscStop_reg && !loadCal |=> $stable(calTime))
    else $error("counters moved with oscillator stopped");
  countRun_a: assert property (!oscStop_reg && tickCnt_reg == 24'h000000
      |=> tickCnt_reg == 24'h000001)
    else $error("time base stalled");

  // Select, reset pin, oscillator, century and side port guards
  sequence secWrite;
    wrHit && isClk && idx == IDX_SEC;
  endsequence
  sequence frozenCtrlWrite;
    wrHit && isClk && idx == IDX_CTRL && (wBit_reg || rBit_reg);
  endsequence

  deselFloat_a: assert property (chipSelN |=> dataLineEnN)
    else $error("data lines driven while deselected");
  pfNoRead_a: assert property (!supplyOk |=> !rdPend_reg)
    else $error("read taken during supply fault");
  rstRelease_a: assert property (supplyOk |=> rstLineEnN)
    else $error("reset pin held low with supply good");
  oscWrite_a: assert property (secWrite
      |=> oscStop_reg == $past(dataLineIn[SEC_OSC_BIT]))
    else $error("oscillator stop bit not taken");
  centKeep_a: assert property (frozenCtrlWrite |=> $stable(vis_reg[IDX_CTRL]))
    else $error("century changed by a freeze write");
  bfShow_a: assert property (rdHit && isClk && idx == IDX_DAY
      |=> clkByte_reg[DAY_BF_BIT] == $past(backupOk))
    else $error("backup flag not shown in day byte");
  tickSet_a: assert property (tick |=> stat_reg[IRQ_TICK_BIT])
    else $error("tick not recorded in status");
  maskRead_a: assert property (irqRd && irqAddr == IRQ_ADDR_MASK |=> irqRdata == $past(mask_reg))
    else $error("mask read back wrong");
  irqLevel_a: assert property (|(stat_reg & mask_reg) |-> irq)
    else $error("interrupt low with unmasked status");
endmodule : nvr_top

//--- tb/nvr_host.sv
/*
  Host model on the byte bus of the timekeeping RAM.
  Assumes the testbench calls access and wires every pin to nvr_top.
*/
`timescale 1ns/1ps
module nvr_host
  import nvr_pkg::*;
(
  // Clock
  input wire logic clock,
  // Byte bus
  output logic [ADDR_W-1:0] addrLine,
  output logic [7:0] busWire,
  output logic chipSelN,
  output logic outEnN,
  output logic writeEnN,
  input wire logic [7:0] dataLineOut,
  input wire logic dataLineEnN
);
  logic [7:0] hostData = 8'h00;
  logic hostDrive = 1'b0;
  logic [7:0] lastVal = 8'h00;
  // A floating bus must not look like valid data
  assign busWire = hostDrive ? hostData : (dataLineEnN ? ~lastVal : dataLineOut);
  always @(posedge clock) lastVal <= busWire;
  initial begin
    addrLine = '0;
    chipSelN = 1'b1;
    outEnN = 1'b1;
    writeEnN = 1'b1;
  end
  task automatic access(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic csN,
                        input logic oeN, input logic weN, output logic [7:0] q,
                        output logic en, output logic enAfter);
    @(posedge clock);
    addrLine <= a;
    hostData <= d;
    hostDrive <= !weN;
    chipSelN <= csN;
    outEnN <= oeN;
    writeEnN <= weN;
    // Reads are held two edges so the registered data is up
    repeat (weN ? 2 : 1) @(posedge clock);
    #1;
    q = busWire;
    en = dataLineEnN;
    @(posedge clock);
    hostDrive <= 1'b0;
    chipSelN <= 1'b1;
    outEnN <= 1'b1;
    writeEnN <= 1'b1;
    @(posedge clock);
    #1;
    enAfter = dataLineEnN;
  endtask : access
endmodule : nvr_host

//--- tb/nv_timekeeping_sram_rtc_test.sv
/*
  Testbench for nvr_top: storage, clock set and freeze, calendar rollover,
  power fail and interrupt side port. Assumes a scaled tick of 20 cycles.
*/
`timescale 1ns/1ps
module nv_timekeeping_sram_rtc_test
  import nvr_pkg::*;
;
  localparam int TICK = 20;
  localparam logic [63:0] RST_VIEW = 64'h00_01_01_81_00_00_00_20;
  // Bytes from year down to control, each set at 23:59:59 with the oscillator stopped
  localparam logic [63:0] START [6] = '{64'h24_02_28_03_23_59_D9_20,
    64'h00_02_28_07_23_59_D9_21, 64'h00_02_28_01_23_59_D9_20,
    64'h99_12_31_05_23_59_D9_20, 64'h23_04_30_02_23_59_D9_20, 64'h23_02_28_06_23_59_D9_20};
  localparam logic [63:0] EXPV [6] = '{64'h24_02_29_84_00_00_02_60,
    64'h00_03_01_81_00_00_02_61, 64'h00_02_29_82_00_00_02_60,
    64'h00_01_01_86_00_00_02_61, 64'h23_05_01_83_00_00_02_60, 64'h23_03_01_87_00_00_02_60};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic supplyOk = 1'b1;
  logic backupOk = 1'b1;
  logic irqAddr = 1'b0;
  logic [7:0] irqWdata = 8'h00;
  logic irqWr = 1'b0;
  logic irqRd = 1'b0;
  logic [ADDR_W-1:0] addrLine;
  logic [7:0] busWire, dataLineOut, irqRdata, q, s;
  logic dataLineEnN, chipSelN, outEnN, writeEnN, rstLineOut, rstLineEnN, irq, en, enA;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  nvr_host host (.clock(clock), .addrLine(addrLine), .busWire(busWire), .chipSelN(chipSelN),
    .outEnN(outEnN), .writeEnN(writeEnN), .dataLineOut(dataLineOut),
    .dataLineEnN(dataLineEnN));
  nvr_top #(.TICK_CYCLES_P(TICK)) dut (.clock(clock), .rst_n(rst_n), .addrLine(addrLine),
    .dataLineIn(busWire), .dataLineOut(dataLineOut), .dataLineEnN(dataLineEnN),
    .chipSelN(chipSelN), .outEnN(outEnN), .writeEnN(writeEnN), .supplyOk(supplyOk),
    .backupOk(backupOk), .rstLineOut(rstLineOut), .rstLineEnN(rstLineEnN),
    .irqAddr(irqAddr), .irqWdata(irqWdata), .irqWr(irqWr), .irqRd(irqRd),
    .irqRdata(irqRdata), .irq(irq));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [ADDR_W-1:0] ca(input int i);
    return CLK_BASE + ADDR_W'(i);
  endfunction : ca
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    host.access(a, d, 1'b0, 1'b1, 1'b0, q, en, enA);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    host.access(a, 8'h00, 1'b0, 1'b0, 1'b1, q, en, enA);
    check(q, exp);
    check({7'h00, en}, 8'h00);
    check({7'h00, enA}, 8'h01);
  endtask : rd
  task automatic irqWrite(input logic a, input logic [7:0] d);
    @(posedge clock);
    irqAddr <= a;
    irqWdata <= d;
    irqWr <= 1'b1;
    @(posedge clock);
    irqWr <= 1'b0;
  endtask : irqWrite
  task automatic irqRead(input logic a, output logic [7:0] d);
    @(posedge clock);
    irqAddr <= a;
    irqRd <= 1'b1;
    @(posedge clock);
    irqRd <= 1'b0;
    #1;
    d = irqRdata;
  endtask : irqRead
  // Clears the tick status and waits for the next scaled 20-cycle tick
  task automatic waitTick();
    logic [7:0] t;
    irqWrite(IRQ_ADDR_STAT, 8'h01);
    for (int i = 0; i < 20; i++) begin
      irqRead(IRQ_ADDR_STAT, t);
      if (t[IRQ_TICK_BIT] === 1'b1) break;
    end
    check({7'h00, t[IRQ_TICK_BIT]}, 8'h01);
  endtask : waitTick
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    #1 check({7'h00, rstLineEnN}, 8'h00);
    check({7'h00, dataLineEnN}, 8'h01);
    repeat (2) @(posedge clock);
    #1 check({6'h00, rstLineEnN, rstLineOut}, 8'h02);
    for (int i = 0; i < 8; i++) begin
      if (i != 1) rd(ca(i), RST_VIEW[8*i +: 8]);
    end
    wr(15'h0000, 8'hA5);
    wr(15'h7FF7, 8'h3C);
    host.access(15'h7FF7, 8'h11, 1'b1, 1'b1, 1'b0, q, en, enA);
    check({7'h00, enA}, 8'h01);
    host.access(15'h0000, 8'h5A, 1'b0, 1'b0, 1'b0, q, en, enA);
    host.access(15'h0000, 8'h00, 1'b0, 1'b1, 1'b1, q, en, enA);
    check({7'h00, en}, 8'h01);
    rd(15'h7FF7, 8'h3C);
    rd(15'h0000, 8'h5A);
    @(posedge clock) backupOk <= 1'b0;
    rd(ca(IDX_DAY), 8'h01);
    irqRead(IRQ_ADDR_STAT, s);
    check(s & 8'h04, 8'h04);
    @(posedge clock) backupOk <= 1'b1;
    @(posedge clock) supplyOk <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check({7'h00, rstLineEnN}, 8'h00);
    host.access(15'h0000, 8'h77, 1'b0, 1'b1, 1'b0, q, en, enA);
    host.access(15'h0000, 8'h00, 1'b0, 1'b0, 1'b1, q, en, enA);
    check({7'h00, en}, 8'h01);
    irqRead(IRQ_ADDR_STAT, s);
    check(s & 8'h02, 8'h02);
    check({7'h00, irq}, 8'h00);
    irqWrite(IRQ_ADDR_MASK, 8'h02);
    repeat (2) @(posedge clock);
    #1 check({7'h00, irq}, 8'h01);
    irqRead(IRQ_ADDR_MASK, s);
    check(s, 8'h02);
    irqWrite(IRQ_ADDR_STAT, 8'h02);
    repeat (2) @(posedge clock);
    #1 check({7'h00, irq}, 8'h00);
    @(posedge clock) supplyOk <= 1'b1;
    repeat (2) @(posedge clock);
    rd(15'h0000, 8'h5A);
    // Frequency test bit is stored and read back beside the backup flag
    wr(ca(IDX_DAY), 8'h40);
    rd(ca(IDX_DAY), 8'hC1);
    wr(ca(IDX_DAY), 8'h00);
    rd(ca(IDX_DAY), 8'h81);
    for (int k = 0; k < 6; k++) begin
      wr(ca(IDX_CTRL), 8'h80);
      for (int i = 1; i < 8; i++) wr(ca(i), START[k][8*i +: 8]);
      wr(ca(IDX_CTRL), START[k][7:0]);
      repeat (30) @(posedge clock);
      rd(ca(IDX_SEC), 8'hD9);
      irqWrite(IRQ_ADDR_STAT, 8'h01);
      wr(ca(IDX_SEC), 8'h59);
      waitTick();
      wr(ca(IDX_CTRL), 8'h40);
      waitTick();
      rd(ca(IDX_SEC), 8'h00);
      wr(ca(IDX_CTRL), 8'h00);
      // Release span covers a whole scaled tick before the next freeze
      waitTick();
      wr(ca(IDX_CTRL), 8'h40);
      for (int i = 0; i < 8; i++) rd(ca(i), EXPV[k][8*i +: 8]);
      wr(ca(IDX_CTRL), 8'h00);
    end
    wrap_up();
  end
endmodule : nv_timekeeping_sram_rtc_test
